//--- rtl/plpm_pkg.sv
// package for the link power manager: constants, register map, carriers
package plpm_pkg;
  // clock and times as specified
  localparam int CLK_MHZ = 250;
  localparam int T_INACT_NS = 2600;
  localparam int T_DIS_NS = 26000;
  localparam int T_WAKE_US = 7300;
  localparam int LKON_PERIOD_NS = 163;

  // least times round up to whole cycles
  function automatic int ns_ceil(input int ns);
    return (ns * CLK_MHZ + 999) / 1000;
  endfunction

  localparam int INACT_CYC = ns_ceil(T_INACT_NS);
  localparam int DIS_CYC = ns_ceil(T_DIS_NS);
  // longest time rounds down
  localparam int WAKE_CYC = T_WAKE_US * CLK_MHZ;
  localparam int LKON_HALF_CYC = (LKON_PERIOD_NS * CLK_MHZ) / 2000;

  localparam int LOW_W = 16;
  localparam int WAKE_W = 21;
  localparam int HALF_W = 5;

  // register byte offsets
  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_IRQ = 4'h4;
  localparam logic [3:0] ADR_STAT = 4'h8;

  // control register fields
  localparam int CTRL_LINK_CONTROL_BIT = 0;
  localparam int CTRL_RESUMING_PORT_IRQ_ENABLE = 1;
  localparam int CTRL_PIE = 2;
  localparam int CTRL_PDIS = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;

  // interrupt flag fields
  localparam int IRQ_PEI = 0;
  localparam int IRQ_CONFIG_TIMEOUT_IRQ_BIT = 1;
  localparam int IRQ_CABLE_POWER_IRQ_BIT = 2;
  localparam int IRQ_STATE_TIMEOUT_IRQ_BIT = 3;

  typedef enum logic [1:0] {IF_NORMAL, IF_RESET, IF_DISABLED, IF_WAKE} plpm_if_e;

  // pins sampled from outside the clock domain
  typedef struct packed {
    logic link_power_status;
    logic pd;
    logic contender;
    logic [2:0] power_class;
    logic bias_in;
    logic connected;
    logic suspended;
  } plpm_pin_s;

  // phy-to-link interface controls
  typedef struct packed {
    logic interface_clock_output_en;
    logic hold_zero;
    logic link_request_input_ignore;
  } plpm_lli_s;
endpackage

//--- rtl/plpm_top.sv
// link power and wake manager of a one-port serial-bus phy
// Contract
// - latch three power-class straps and contender as self-id defaults
// - during hardware reset read contender/link-on pin as input for contender default
// - suspended port neither sends nor receives, but still sees bias and connection
// - port transceiver off on power-down, reset, no cable, or arbitration request
// - port bias off on power-down, reset, or link-commanded port disable
// - cable-not-active high when no incoming bias; no debounce
// - power-down keeps cable-not-active detection alive and forces internal reset
// - interface state follows link power status only, not link control bit
// - link power status inactive only after low for over 2.6 us
// - inactive status gives reset state: outputs zero, request ignored, clock runs
// - low over 26 us gives disabled state, clock stopped; also during reset
// - repeater functions keep running in every interface state
// - status active again in reset or disabled returns interface to normal
// - disabled interface and idle port enter low-power mode, clock generators stop
// - deepest sleep when port disconnected, or disabled with its irq enable clear
// - leave low-power mode on status high or a port event needing response
// - after status rises in low-power mode, clock and interface back within 7.3 ms
// - active link-on output is a square wave of about 163 ns period
// - link-on activates on wake event while link inactive (status low or control 0)
// - wake events: link-on packet for this node, or enabled pending phy interrupt
// - link-on stops once status active and link control bit is one
// - bus reset stops link-on unless a wake-causing interrupt is pending
// - inactive link-on driven low, but high impedance during hardware reset
// - port-event irq wakes; timeout, cable-power, state irqs wake if resume enable set
// - pending wake irq while link active fires link-on when link goes inactive
`timescale 1ns/1ps
module plpm_top #(
  parameter int DIS_CYCLES = plpm_pkg::DIS_CYC,
  parameter int WAKE_CYCLES = plpm_pkg::WAKE_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire plpm_pkg::plpm_pin_s pins_i,
  input wire logic arb_disable_i,
  input wire logic port_event_i,
  input wire logic linkon_pkt_i,
  input wire logic bus_reset_i,
  input wire logic [3:0] irq_set_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output plpm_pkg::plpm_lli_s lli_o,
  output logic port_txrx_en_o,
  output logic port_bias_en_o,
  output logic cable_not_active_o,
  output logic clkgen_stop_o,
  output logic deep_sleep_o,
  output logic repeater_en_o,
  output logic [2:0] power_class_o,
  output logic contender_o,
  output logic lkon_o,
  output logic lkon_oe_o
);
  // checks below all run on the one clock and stand down during hardware reset
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // two-stage synchroniser; first stage read only by the second
  plpm_pkg::plpm_pin_s meta_q;
  plpm_pkg::plpm_pin_s pin_q;
  always_ff @(posedge clk_i) begin
    meta_q <= pins_i;
    pin_q <= meta_q;
  end

  // power-down acts as an internal reset
  logic int_rst;
  assign int_rst = rst_i | pin_q.pd;

  // strap capture while hardware reset is held
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      power_class_o <= pin_q.power_class;
      contender_o <= pin_q.contender;
    end
  end

  // control register and irq flags
  logic [3:0] ctrl_q;
  logic [3:0] irq_q;
  logic wr_en;
  logic rd_en;
  assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
  assign rd_en = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;

  always_ff @(posedge clk_i) begin
    if (int_rst) begin
      ctrl_q <= plpm_pkg::CTRL_RST;
    end else if (wr_en && wb_adr_i == plpm_pkg::ADR_CTRL) begin
      ctrl_q <= wb_dat_i[3:0];
    end
  end

  // write one to clear; a set in the same cycle wins
  always_ff @(posedge clk_i) begin
    if (int_rst) begin
      irq_q <= 4'h0;
    end else if (wr_en && wb_adr_i == plpm_pkg::ADR_IRQ) begin
      irq_q <= (irq_q & ~wb_dat_i[3:0]) | irq_set_i;
    end else begin
      irq_q <= irq_q | irq_set_i;
    end
  end

  logic link_control_bit;
  logic resuming_port_irq_enable;
  logic pie;
  logic pdis;
  assign link_control_bit = ctrl_q[plpm_pkg::CTRL_LINK_CONTROL_BIT];
  assign resuming_port_irq_enable = ctrl_q[plpm_pkg::CTRL_RESUMING_PORT_IRQ_ENABLE];
  assign pie = ctrl_q[plpm_pkg::CTRL_PIE];
  assign pdis = ctrl_q[plpm_pkg::CTRL_PDIS];

  // low-time counter of link power status, saturating past the disable limit
  logic [plpm_pkg::LOW_W-1:0] low_cnt_q;
  always_ff @(posedge clk_i) begin
    if (int_rst || pin_q.link_power_status) begin
      low_cnt_q <= '0;
    end else if (low_cnt_q <= plpm_pkg::LOW_W'(DIS_CYCLES)) begin
      low_cnt_q <= low_cnt_q + 1'b1;
    end
  end

  logic lps_active;
  logic lps_dis;
  assign lps_active = low_cnt_q <= plpm_pkg::LOW_W'(plpm_pkg::INACT_CYC);
  assign lps_dis = low_cnt_q > plpm_pkg::LOW_W'(DIS_CYCLES);

  // low-power mode: interface disabled and port idle
  logic lp_q;
  logic port_idle;
  logic wake_evt;
  assign port_idle = ~pin_q.connected | pdis | pin_q.suspended;
  assign wake_evt = pin_q.link_power_status | port_event_i;

  plpm_pkg::plpm_if_e state_q;
  logic [plpm_pkg::WAKE_W-1:0] wake_cnt_q;

  always_ff @(posedge clk_i) begin
    if (int_rst) begin
      lp_q <= 1'b0;
    end else if (lp_q) begin
      lp_q <= ~wake_evt;
    end else begin
      lp_q <= state_q == plpm_pkg::IF_DISABLED && port_idle && !wake_evt;
    end
  end

  // deepest sleep needs a dead port or a disabled one with its port irq enable off
  always_ff @(posedge clk_i) begin
    if (int_rst) begin
      deep_sleep_o <= 1'b0;
    end else begin
      deep_sleep_o <= lp_q & (~pin_q.connected | (pdis & ~pie));
    end
  end

  always_ff @(posedge clk_i) begin
    if (int_rst) begin
      clkgen_stop_o <= 1'b0;
    end else begin
      clkgen_stop_o <= lp_q;
    end
  end

  // interface state driven by link power status alone; control bit unused here
  always_ff @(posedge clk_i) begin
    if (int_rst) begin
      state_q <= plpm_pkg::IF_DISABLED;
    end else begin
      unique case (state_q)
        plpm_pkg::IF_NORMAL: begin
          if (!lps_active) begin
            state_q <= plpm_pkg::IF_RESET;
          end
        end
        plpm_pkg::IF_RESET: begin
          if (lps_dis) begin
            state_q <= plpm_pkg::IF_DISABLED;
          end else if (pin_q.link_power_status) begin
            state_q <= plpm_pkg::IF_NORMAL;
          end
        end
        plpm_pkg::IF_DISABLED: begin
          if (pin_q.link_power_status && lp_q) begin
            state_q <= plpm_pkg::IF_WAKE;
          end else if (pin_q.link_power_status) begin
            state_q <= plpm_pkg::IF_NORMAL;
          end
        end
        plpm_pkg::IF_WAKE: begin
          if (wake_cnt_q == '0) begin
            state_q <= plpm_pkg::IF_NORMAL;
          end
        end
      endcase
    end
  end

  // clock generator restart time, bounded by the wake limit
  always_ff @(posedge clk_i) begin
    if (int_rst || state_q != plpm_pkg::IF_WAKE) begin
      wake_cnt_q <= plpm_pkg::WAKE_W'(WAKE_CYCLES - 2);
    end else if (wake_cnt_q != '0) begin
      wake_cnt_q <= wake_cnt_q - 1'b1;
    end
  end

  // interface outputs: clock runs only in normal and reset states
  always_ff @(posedge clk_i) begin
    if (int_rst) begin
      lli_o <= '{interface_clock_output_en: 1'b0, hold_zero: 1'b1, link_request_input_ignore: 1'b1};
    end else begin
      lli_o.interface_clock_output_en <= state_q == plpm_pkg::IF_NORMAL || state_q == plpm_pkg::IF_RESET;
      lli_o.hold_zero <= state_q != plpm_pkg::IF_NORMAL;
      lli_o.link_request_input_ignore <= state_q != plpm_pkg::IF_NORMAL;
    end
  end

  // port gating; independent of the interface state so repeating goes on
  always_ff @(posedge clk_i) begin
    if (int_rst) begin
      port_txrx_en_o <= 1'b0;
      port_bias_en_o <= 1'b0;
      repeater_en_o <= 1'b0;
    end else begin
      port_txrx_en_o <= pin_q.connected & ~pin_q.suspended & ~arb_disable_i;
      port_bias_en_o <= ~pdis;
      repeater_en_o <= 1'b1;
    end
  end

  // bias detection stays alive through power-down; no debounce by design
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cable_not_active_o <= 1'b1;
    end else begin
      cable_not_active_o <= ~pin_q.bias_in;
    end
  end

  // wake logic for the link-on output
  logic link_active;
  logic irq_wake;
  logic lkon_act_q;
  assign link_active = lps_active & link_control_bit;
  assign irq_wake = irq_q[plpm_pkg::IRQ_PEI] | (resuming_port_irq_enable & (irq_q[plpm_pkg::IRQ_CONFIG_TIMEOUT_IRQ_BIT]
    | irq_q[plpm_pkg::IRQ_CABLE_POWER_IRQ_BIT] | irq_q[plpm_pkg::IRQ_STATE_TIMEOUT_IRQ_BIT]));

  // pending irq re-fires as soon as the link drops, since it is level-based
  always_ff @(posedge clk_i) begin
    if (int_rst) begin
      lkon_act_q <= 1'b0;
    end else if (link_active) begin
      lkon_act_q <= 1'b0;
    end else if (irq_wake || linkon_pkt_i) begin
      lkon_act_q <= 1'b1;
    end else if (bus_reset_i) begin
      lkon_act_q <= 1'b0;
    end
  end

  // square wave generator
  logic [plpm_pkg::HALF_W-1:0] half_cnt_q;
  logic phase_q;
  always_ff @(posedge clk_i) begin
    if (int_rst || !lkon_act_q) begin
      half_cnt_q <= '0;
      phase_q <= 1'b0;
    end else if (half_cnt_q == plpm_pkg::HALF_W'(plpm_pkg::LKON_HALF_CYC - 1)) begin
      half_cnt_q <= '0;
      phase_q <= ~phase_q;
    end else begin
      half_cnt_q <= half_cnt_q + 1'b1;
    end
  end

  // pin released during hardware reset so the contender strap can be read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lkon_o <= 1'b0;
      lkon_oe_o <= 1'b0;
    end else begin
      lkon_o <= lkon_act_q & ~phase_q;
      lkon_oe_o <= 1'b1;
    end
  end

  // bus slave: one wait state, unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0;
    end else if (rd_en) begin
      unique case (wb_adr_i)
        plpm_pkg::ADR_CTRL: wb_dat_o <= {28'h0, ctrl_q};
        plpm_pkg::ADR_IRQ: wb_dat_o <= {28'h0, irq_q};
        plpm_pkg::ADR_STAT: wb_dat_o <= {20'h0, contender_o, power_class_o,
          cable_not_active_o, lkon_act_q, deep_sleep_o, lp_q, lps_active, 1'b0,
          state_q};
        default: wb_dat_o <= 32'h0;
      endcase
    end
  end

  // checks
  logic [plpm_pkg::LOW_W-1:0] chk_low_q;
  always_ff @(posedge clk_i) begin
    if (rst_i || pin_q.link_power_status) begin
      chk_low_q <= '0;
    end else if (chk_low_q != '1) begin
      chk_low_q <= chk_low_q + 1'b1;
    end
  end

  // time spent in the wake state; the full limit is far too long for a delay range
  logic [plpm_pkg::WAKE_W-1:0] wake_age_q;
  always_ff @(posedge clk_i) begin
    if (rst_i || state_q != plpm_pkg::IF_WAKE) begin
      wake_age_q <= '0;
    end else if (wake_age_q != '1) begin
      wake_age_q <= wake_age_q + 1'b1;
    end
  end

  // length of the running phase-high half of the wave (link-on low), counted rather than repeated
  logic [plpm_pkg::HALF_W-1:0] hi_run_q;
  always_ff @(posedge clk_i) begin
    if (rst_i || !phase_q) begin
      hi_run_q <= '0;
    end else if (hi_run_q != '1) begin
      hi_run_q <= hi_run_q + 1'b1;
    end
  end

  lps_inact_a: assert property (chk_low_q > plpm_pkg::LOW_W'(plpm_pkg::INACT_CYC)
    && state_q == plpm_pkg::IF_NORMAL && !pin_q.pd |=> state_q == plpm_pkg::IF_RESET)
    else $error("normal state held after long low status");
  lps_short_a: assert property (state_q == plpm_pkg::IF_NORMAL && pin_q.link_power_status
    && !pin_q.pd |=> state_q == plpm_pkg::IF_NORMAL)
    else $error("normal state left while status high");
  reset_out_a: assert property (state_q == plpm_pkg::IF_RESET && !pin_q.pd
    |=> lli_o.hold_zero && lli_o.link_request_input_ignore && lli_o.interface_clock_output_en)
    else $error("reset state outputs wrong");
  disabled_clk_a: assert property (state_q == plpm_pkg::IF_DISABLED && !pin_q.pd
    |=> !lli_o.interface_clock_output_en)
    else $error("clock running in disabled state");
  return_norm_a: assert property (state_q == plpm_pkg::IF_RESET && pin_q.link_power_status
    && !lps_dis && !pin_q.pd |=> state_q == plpm_pkg::IF_NORMAL)
    else $error("reset state not left on active status");
  wake_time_a: assert property (state_q == plpm_pkg::IF_WAKE
    |-> wake_age_q < plpm_pkg::WAKE_W'(WAKE_CYCLES))
    else $error("wake state held too long");
  lkon_stop_a: assert property (link_active && !pin_q.pd |=> !lkon_act_q)
    else $error("link-on active with link active");
  lkon_start_a: assert property (!link_active && irq_wake && !pin_q.pd
    |=> lkon_act_q)
    else $error("link-on not started on wake irq");
  bus_rst_a: assert property (bus_reset_i && !irq_wake && !linkon_pkt_i
    && !pin_q.pd |=> !lkon_act_q)
    else $error("link-on kept after bus reset");
  lkon_low_a: assert property (!lkon_act_q |=> !lkon_o && lkon_oe_o)
    else $error("link-on not driven low when idle");
  lkon_wave_a: assert property (lkon_act_q && $past(lkon_act_q) && $fell(phase_q)
    |-> hi_run_q == plpm_pkg::HALF_W'(plpm_pkg::LKON_HALF_CYC))
    else $error("link-on half period wrong");
  cna_a: assert property (!pin_q.bias_in |=> cable_not_active_o)
    else $error("cable-not-active low without bias");

  wake_c: cover property (state_q == plpm_pkg::IF_WAKE ##1 state_q == plpm_pkg::IF_NORMAL);
  lkon_c: cover property ($rose(lkon_act_q));
  sleep_c: cover property ($rose(deep_sleep_o));
endmodule

//--- bench/plpm_llc_model.sv
// behavioural link-layer controller that drives link power status
`timescale 1ns/1ps
module plpm_llc_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic want_on_i,
  input wire logic [7:0] lag_i,
  output logic lps_o
);
  logic [7:0] lag_q;

  // the status follows the wish only after lag_i cycles, so answers come promptly or slowly
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lag_q <= 8'h00;
      lps_o <= 1'b0;
    end else if (lps_o == want_on_i) begin
      lag_q <= 8'h00;
    end else if (lag_q >= lag_i) begin
      lps_o <= want_on_i;
      lag_q <= 8'h00;
    end else begin
      lag_q <= lag_q + 8'h01;
    end
  end
endmodule

//--- bench/tb_phy_link_power_manager.sv
// self-checking bench for the link power and wake manager
`timescale 1ns/1ps
module tb_phy_link_power_manager;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic want_on = 1'b1;
  logic [7:0] lag = 8'h00;
  logic link_power_status;
  logic pd = 1'b0;
  logic cont = 1'b1;
  logic [2:0] pc = 3'h5;
  logic bias = 1'b1;
  logic conn = 1'b1;
  logic susp = 1'b0;
  logic arb = 1'b0;
  logic pev = 1'b0;
  logic pkt = 1'b0;
  logic breset = 1'b0;
  logic [3:0] irq_set = 4'h0;
  logic [3:0] wb_adr = 4'h0;
  logic [31:0] wb_dat = 32'h0;
  logic [3:0] wb_sel = 4'h0;
  logic wb_we = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  plpm_pkg::plpm_pin_s pins;
  plpm_pkg::plpm_lli_s lli_o;
  logic txrx, bias_en, cable_not_active_output, clkstop, deep, rep, contender_o, lkon_o, lkon_oe;
  logic [2:0] pc_o;
  logic [31:0] rd;
  int n_fail = 0;
  int check_count = 0;
  int cyc_n = 0;

  always #2 clk_i = ~clk_i;

  assign pins = {link_power_status, pd, cont, pc, bias, conn, susp};

  plpm_llc_model llc_u (.clk_i(clk_i), .rst_i(rst_i), .want_on_i(want_on), .lag_i(lag),
    .lps_o(link_power_status));

  // small disable and wake counts keep the run short
  plpm_top #(.DIS_CYCLES(800), .WAKE_CYCLES(10)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
    .pins_i(pins), .arb_disable_i(arb), .port_event_i(pev), .linkon_pkt_i(pkt),
    .bus_reset_i(breset), .irq_set_i(irq_set), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat),
    .wb_sel_i(wb_sel), .wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .lli_o(lli_o), .port_txrx_en_o(txrx),
    .port_bias_en_o(bias_en), .cable_not_active_o(cable_not_active_output), .clkgen_stop_o(clkstop),
    .deep_sleep_o(deep), .repeater_en_o(rep), .power_class_o(pc_o),
    .contender_o(contender_o), .lkon_o(lkon_o), .lkon_oe_o(lkon_oe));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // cut a hang short; the whole sequence needs well under 20000 cycles
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n > 40000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h", $time, msg, got);
    end
  endtask

  task automatic cy(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // one classic cycle; read data is taken at the edge where ack is seen
  task automatic wb_go(input logic [3:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_adr <= a;
    wb_we <= w;
    wb_dat <= d;
    wb_sel <= 4'hf;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    chk(n < 20, 1, "no ack");
  endtask

  task automatic stat(input int b, input logic e, input string msg);
    wb_go(plpm_pkg::ADR_STAT, 1'b0, 32'h0);
    chk(rd[b], e, msg);
  endtask

  // measures one high and one low phase of the link-on wave
  task automatic lkon_wave;
    int h, l;
    h = 0;
    l = 0;
    while (lkon_o !== 1'b1 && h < 10) begin
      @(posedge clk_i);
      h++;
    end
    h = 0;
    while (lkon_o === 1'b1 && h < 50) begin
      @(posedge clk_i);
      h++;
    end
    while (lkon_o !== 1'b1 && l < 50) begin
      @(posedge clk_i);
      l++;
    end
    chk(h, plpm_pkg::LKON_HALF_CYC, "lkon high");
    chk(l, plpm_pkg::LKON_HALF_CYC, "lkon low");
  endtask

  initial begin
    cy(8);
    chk(lkon_oe, 0, "lkon oe in reset");
    chk(lli_o, 3'b011, "lli in reset");
    chk({txrx, bias_en}, 0, "port in reset");
    rst_i <= 1'b0;
    cy(20);
    chk({rep, lkon_oe}, 2'b11, "after reset");
    chk({pc_o, contender_o}, 4'hb, "straps");
    $display("test reset done");
    wb_go(plpm_pkg::ADR_CTRL, 1'b1, 32'h6);
    wb_go(plpm_pkg::ADR_CTRL, 1'b0, 32'h0);
    chk(rd, 32'h6, "ctrl readback");
    wb_go(4'hc, 1'b0, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    chk({lli_o, txrx, bias_en}, 5'h13, "normal");
    $display("test regs done");
    // link control bit is 0 here, so only link power status moves the interface
    want_on <= 1'b0;
    cy(600);
    want_on <= 1'b1;
    cy(10);
    chk(lli_o, 3'b100, "short low");
    want_on <= 1'b0;
    cy(700);
    chk(lli_o, 3'b111, "reset state");
    cy(200);
    chk(lli_o, 3'b011, "disabled");
    lag <= 8'h32;
    want_on <= 1'b1;
    cy(70);
    chk(lli_o, 3'b100, "back normal");
    lag <= 8'h00;
    $display("test interface done");
    conn <= 1'b0;
    bias <= 1'b0;
    want_on <= 1'b0;
    cy(900);
    chk({cable_not_active_output, txrx}, 2'b10, "no cable");
    chk({clkstop, deep}, 2'b11, "low power");
    want_on <= 1'b1;
    cy(30);
    chk({clkstop, lli_o}, 4'h4, "wake by status");
    want_on <= 1'b0;
    cy(900);
    pev <= 1'b1;
    cy(6);
    chk(clkstop, 0, "wake by event");
    pev <= 1'b0;
    want_on <= 1'b1;
    conn <= 1'b1;
    bias <= 1'b1;
    cy(30);
    wb_go(plpm_pkg::ADR_CTRL, 1'b1, 32'h8);
    want_on <= 1'b0;
    cy(900);
    chk({clkstop, deep}, 2'b11, "deep by port disable");
    wb_go(plpm_pkg::ADR_CTRL, 1'b1, 32'hc);
    cy(3);
    chk({clkstop, deep}, 2'b10, "light with irq enable");
    want_on <= 1'b1;
    cy(30);
    wb_go(plpm_pkg::ADR_CTRL, 1'b1, 32'h6);
    $display("test low power done");
    pkt <= 1'b1;
    cy(1);
    pkt <= 1'b0;
    lkon_wave();
    breset <= 1'b1;
    cy(1);
    breset <= 1'b0;
    cy(4);
    stat(6, 1'b0, "bus reset stops");
    irq_set <= 4'h1;
    cy(1);
    irq_set <= 4'h0;
    lkon_wave();
    breset <= 1'b1;
    cy(1);
    breset <= 1'b0;
    cy(4);
    stat(6, 1'b1, "irq keeps");
    wb_go(plpm_pkg::ADR_CTRL, 1'b1, 32'h7);
    cy(3);
    stat(6, 1'b0, "link active");
    want_on <= 1'b0;
    cy(700);
    stat(6, 1'b1, "pending irq");
    want_on <= 1'b1;
    cy(20);
    wb_go(plpm_pkg::ADR_IRQ, 1'b1, 32'hf);
    for (int i = 1; i < 4; i++) begin
      wb_go(plpm_pkg::ADR_CTRL, 1'b1, 32'h4);
      irq_set <= 4'(1 << i);
      cy(1);
      irq_set <= 4'h0;
      wb_go(plpm_pkg::ADR_IRQ, 1'b0, 32'h0);
      chk(rd, 32'(1 << i), "irq flag");
      stat(6, 1'b0, "no resume enable");
      wb_go(plpm_pkg::ADR_CTRL, 1'b1, 32'h6);
      cy(3);
      stat(6, 1'b1, "resume enable");
      wb_go(plpm_pkg::ADR_CTRL, 1'b1, 32'h7);
      wb_go(plpm_pkg::ADR_IRQ, 1'b1, 32'hf);
    end
    $display("test link-on done");
    susp <= 1'b1;
    cy(6);
    chk(txrx, 0, "suspended");
    susp <= 1'b0;
    arb <= 1'b1;
    cy(6);
    chk(txrx, 0, "arbitration off");
    arb <= 1'b0;
    wb_go(plpm_pkg::ADR_CTRL, 1'b1, 32'hf);
    cy(3);
    chk({txrx, bias_en}, 2'b10, "port disabled");
    wb_go(plpm_pkg::ADR_CTRL, 1'b1, 32'h7);
    pd <= 1'b1;
    cy(6);
    chk({txrx, bias_en, lli_o}, 5'h3, "power down");
    bias <= 1'b0;
    cy(6);
    chk(cable_not_active_output, 1, "cna in power down");
    bias <= 1'b1;
    cy(6);
    chk(cable_not_active_output, 0, "cna follows bias");
    pd <= 1'b0;
    cy(10);
    $display("test port done");
    tally_and_finish();
  end
endmodule
